//--- core/irw_pkg.sv
// Constants and types for the interrupt routing and wakeup block.
`default_nettype none
package irw_pkg;
  localparam int unsigned NUM_IRQ        = 32;
  localparam int unsigned NUM_EXT        = 4;
  localparam int unsigned EXT_BASE       = 5;
  localparam int unsigned LVD_NUM        = 4;
  localparam int unsigned CAL_NUM        = 30;
  localparam int unsigned TICK_W         = 24;
  localparam int unsigned PRIO_W         = 2;
  localparam int unsigned NUM_WAKE       = 6;
  localparam int unsigned WAKE_LVD_IDX   = 4;
  localparam int unsigned WAKE_CAL_IDX   = 5;
  // Wake active level encodings.
  localparam logic [2:0] LVL_LOW         = 3'h0;
  localparam logic [2:0] LVL_HIGH        = 3'h1;
  localparam logic [2:0] LVL_FALL        = 3'h2;
  localparam logic [2:0] LVL_RISE        = 3'h3;
  // Reset cause bit positions.
  localparam int unsigned CAUSE_PIN      = 0;
  localparam int unsigned CAUSE_WDG      = 1;
  localparam int unsigned CAUSE_SOFT     = 2;
  localparam logic [2:0] CAUSE_RESET_VAL = 3'h1;
  localparam logic [1:0] OSC_SEL_RESET   = 2'h0;

  typedef enum logic [1:0] {
    TICK_IDLE = 2'b00,
    TICK_LOAD = 2'b01,
    TICK_RUN  = 2'b11
  } irw_tick_state_type;

  typedef struct packed {
    logic [NUM_IRQ-1:0]     irq;
    logic [NUM_IRQ-1:0]     pend;
    logic [4:0]             best_id;
    logic                   best_valid;
    logic                   nmi;
    logic                   tick_irq;
    logic                   tick_flag;
    logic [TICK_W-1:0]      tick_cnt;
    irw_tick_state_type     tick_st;
    logic [2:0]             cause;
    logic                   sys_reset;
    logic                   pin_prev;
    logic [NUM_EXT-1:0]     ext_s1;
    logic [NUM_EXT-1:0]     ext_s2;
    logic [NUM_WAKE-1:0]    wake_prev;
    logic [NUM_WAKE-1:0]    wake_hit;
    logic [2:0]             osc_sync;
  } irw_state_type;
endpackage
`default_nettype wire

//--- core/irw_route.sv
// Interrupt routing, standby wakeup detection, reset sources and system tick timer.
// Notes on behaviour
// - Three reset sources: external pin, watchdog unit, software reset request.
// - Pin reset exception raised when the reset pin is released low to high.
// - Writing one to software reset request causes a system reset.
// - Reset cause flags record which source caused the last reset.
// - Watchdog unit can raise a non-maskable request to the core.
// - Enabled tick timer loads reload value then decrements once per tick.
// - Tick counter reaching zero raises the tick exception request.
// - Tick timer sets a pollable flag when the count reaches zero.
// - Tick is clocked by the oscillator chosen by oscillator select.
// - Non-wake peripheral requests go straight to core inputs.
// - Wake peripheral and pin requests pass through standby-release logic.
// - Non-wake external pin requests bypass the standby-release logic.
// - Set-pending bit forces a pending request regardless of source.
// - Non-wake pin sources need no wake configuration; wake sources do.
// - Disabled port input reads high on the internal pin signal.
// - A high level on any core input is an active request.
// - Direct peripheral requests are presented as high levels.
// - Wake peripheral requests detect rising or falling edges.
// - Wake pin requests are high, low, rising or falling sensitive.
// - Each wake source has an enable and active level setting.
// - Wake-detected requests reach the core as high levels.
// - 32 sources numbered 0 to 31; pins 0 to 3 are numbers 5 to 8.
// - Two-bit priority, 0 highest; ties go to the lower number.
`default_nettype none
module irw_route
  import irw_pkg::*;
(
  input  wire logic                    REF_CLK_IN,
  input  wire logic                    SRST_IN,
  input  wire logic                    RESET_PIN_IN,
  input  wire logic                    WATCHDOG_RESET_IN,
  input  wire logic                    WATCHDOG_NMI_IN,
  input  wire logic                    SOFTWARE_RESET_REQUEST_IN,
  input  wire logic [NUM_IRQ-1:0]      PERIPH_IRQ_IN,
  input  wire logic [NUM_EXT-1:0]      EXT_PIN_IN,
  input  wire logic [NUM_EXT-1:0]      PORT_INPUT_ENABLE_REG_IN,
  input  wire logic [NUM_WAKE-1:0]     WAKE_SOURCE_ENABLE_IN,
  input  wire logic [3*NUM_WAKE-1:0]   WAKE_ACTIVE_LEVEL_IN,
  input  wire logic [NUM_IRQ-1:0]      SET_PENDING_IN,
  input  wire logic [NUM_IRQ-1:0]      CLEAR_PENDING_IN,
  input  wire logic [NUM_WAKE-1:0]     WAKE_CLEAR_IN,
  input  wire logic [2*NUM_IRQ-1:0]    PRIORITY_IN,
  input  wire logic [NUM_IRQ-1:0]      IRQ_ENABLE_IN,
  input  wire logic                    TICK_ENABLE_IN,
  input  wire logic [TICK_W-1:0]       TICK_RELOAD_IN,
  input  wire logic                    TICK_FLAG_READ_IN,
  input  wire logic [1:0]              OSCILLATOR_SELECT_IN,
  input  wire logic [3:0]              OSC_TICK_IN,
  output logic [NUM_IRQ-1:0]           CORE_IRQ_OUT,
  output logic [NUM_IRQ-1:0]           PENDING_OUT,
  output logic [4:0]                   ACTIVE_ID_OUT,
  output logic                         ACTIVE_VALID_OUT,
  output logic                         NMI_OUT,
  output logic                         TICK_IRQ_OUT,
  output logic                         TICK_FLAG_OUT,
  output logic [TICK_W-1:0]            TICK_COUNT_OUT,
  output logic [2:0]                   RESET_CAUSE_FLAGS_OUT,
  output logic                         SYSTEM_RESET_OUT
);

  // Maps wake slot to interrupt number.
  function automatic int unsigned wake_num(input int unsigned w);
    if (w < NUM_EXT)
    begin
      return EXT_BASE + w;
    end
    else if (w == WAKE_LVD_IDX)
    begin
      return LVD_NUM;
    end
    return CAL_NUM;
  endfunction

  // Evaluates an active level against current and previous samples.
  function automatic logic level_hit(input logic [2:0] lvl, input logic cur, input logic prv);
    case (lvl)
      LVL_LOW:  return ~cur;
      LVL_HIGH: return cur;
      LVL_FALL: return prv & ~cur;
      LVL_RISE: return ~prv & cur;
      default:  return 1'b0;
    endcase
  endfunction

  // Builds the one-hot cause word for one reset source position.
  function automatic logic [2:0] cause_onehot(input int unsigned pos);
    logic [2:0] c;
    c = 3'h0;
    c[pos] = 1'b1;
    return c;
  endfunction

  // Returns one source's priority field, widened so that no source exceeds the start level.
  function automatic logic [3:0] prio_of(input logic [2*NUM_IRQ-1:0] p, input int unsigned i);
    return {2'b00, p[2*i +: 2]};
  endfunction

  irw_state_type s_q;
  irw_state_type s_d;
  logic [NUM_EXT-1:0]  ext_gated;
  logic [NUM_WAKE-1:0] wake_src;
  logic [NUM_IRQ-1:0]  routed;
  logic                tick_step;
  logic [2:0]          wake_lvl [NUM_WAKE];

  always_comb
  begin
    ext_gated = ~PORT_INPUT_ENABLE_REG_IN | EXT_PIN_IN;
  end

  genvar gw;
  generate
    for (gw = 0; gw < NUM_EXT; gw++)
    begin : g_wsrc
      assign wake_src[gw] = s_q.ext_s2[gw];
    end
  endgenerate
  assign wake_src[WAKE_LVD_IDX] = PERIPH_IRQ_IN[LVD_NUM];
  assign wake_src[WAKE_CAL_IDX] = PERIPH_IRQ_IN[CAL_NUM];

  // Tick step from the registered oscillator select, so a change lands on a clean edge.
  assign tick_step = OSC_TICK_IN[s_q.osc_sync[1:0]];

  genvar gl;
  generate
    for (gl = 0; gl < NUM_WAKE; gl++)
    begin : g_wlvl
      assign wake_lvl[gl] = WAKE_ACTIVE_LEVEL_IN[3*gl +: 3];
    end
  endgenerate

  always_comb
  begin
    logic [3:0] lvl;
    lvl = 4'h0;
    s_d = s_q;
    s_d.osc_sync = {1'b0, OSCILLATOR_SELECT_IN};
    s_d.ext_s1 = ext_gated;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.wake_prev = wake_src;
    // Direct routes for every source, with wake routes overriding below.
    routed = PERIPH_IRQ_IN;
    for (int unsigned e = 0; e < NUM_EXT; e++)
    begin
      routed[EXT_BASE + e] = s_q.ext_s2[e];
    end
    for (int unsigned w = 0; w < NUM_WAKE; w++)
    begin
      if (WAKE_SOURCE_ENABLE_IN[w] && level_hit(wake_lvl[w], wake_src[w], s_q.wake_prev[w]))
      begin
        s_d.wake_hit[w] = 1'b1;
      end
      else if (WAKE_CLEAR_IN[w] || !WAKE_SOURCE_ENABLE_IN[w])
      begin
        s_d.wake_hit[w] = 1'b0;
      end
      if (WAKE_SOURCE_ENABLE_IN[w])
      begin
        routed[wake_num(w)] = s_q.wake_hit[w];
      end
    end
    s_d.irq = routed;
    // Pending: set wins over clear.
    s_d.pend = (s_q.pend & ~CLEAR_PENDING_IN) | SET_PENDING_IN | routed;
    // Priority pick among enabled pending, lowest value then lowest number.
    s_d.best_valid = 1'b0;
    s_d.best_id = 5'h00;
    lvl = 4'h4;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (s_q.pend[i] && IRQ_ENABLE_IN[i] && (prio_of(PRIORITY_IN, i) <= lvl))
      begin
        lvl = prio_of(PRIORITY_IN, i);
        s_d.best_id = 5'(i);
        s_d.best_valid = 1'b1;
      end
    end
    s_d.nmi = WATCHDOG_NMI_IN;
    // Tick timer.
    s_d.tick_irq = 1'b0;
    if (TICK_FLAG_READ_IN)
    begin
      s_d.tick_flag = 1'b0;
    end
    case (s_q.tick_st)
      TICK_IDLE:
      begin
        if (TICK_ENABLE_IN)
        begin
          s_d.tick_st = TICK_LOAD;
        end
      end
      TICK_LOAD:
      begin
        s_d.tick_cnt = TICK_RELOAD_IN;
        if (TICK_ENABLE_IN)
        begin
          s_d.tick_st = TICK_RUN;
        end
        else
        begin
          s_d.tick_st = TICK_IDLE;
        end
      end
      TICK_RUN:
      begin
        if (!TICK_ENABLE_IN)
        begin
          s_d.tick_st = TICK_IDLE;
        end
        else if (tick_step)
        begin
          if (s_q.tick_cnt == '0)
          begin
            s_d.tick_cnt = TICK_RELOAD_IN;
          end
          else
          begin
            s_d.tick_cnt = s_q.tick_cnt - 1'b1;
            if (s_q.tick_cnt == TICK_W'(1))
            begin
              s_d.tick_irq = 1'b1;
              s_d.tick_flag = 1'b1;
            end
          end
        end
      end
      default:
      begin
        s_d.tick_st = TICK_IDLE;
      end
    endcase
    // Reset sources and cause capture.
    s_d.pin_prev = RESET_PIN_IN;
    s_d.sys_reset = 1'b0;
    if (!s_q.pin_prev && RESET_PIN_IN)
    begin
      s_d.sys_reset = 1'b1;
      s_d.cause = cause_onehot(CAUSE_PIN);
    end
    else if (WATCHDOG_RESET_IN)
    begin
      s_d.sys_reset = 1'b1;
      s_d.cause = cause_onehot(CAUSE_WDG);
    end
    else if (SOFTWARE_RESET_REQUEST_IN)
    begin
      s_d.sys_reset = 1'b1;
      s_d.cause = cause_onehot(CAUSE_SOFT);
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (SRST_IN)
    begin
      s_q <= '0;
      s_q.tick_st <= TICK_IDLE;
      s_q.cause <= CAUSE_RESET_VAL;
      s_q.pin_prev <= 1'b1;
      s_q.ext_s1 <= '1;
      s_q.ext_s2 <= '1;
      // Pin history starts at the preset synchroniser level, so no false edge follows reset.
      s_q.wake_prev <= {2'b00, {NUM_EXT{1'b1}}};
      s_q.osc_sync <= {1'b0, OSC_SEL_RESET};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign CORE_IRQ_OUT          = s_q.irq;
  assign PENDING_OUT           = s_q.pend;
  assign ACTIVE_ID_OUT         = s_q.best_id;
  assign ACTIVE_VALID_OUT      = s_q.best_valid;
  assign NMI_OUT               = s_q.nmi;
  assign TICK_IRQ_OUT          = s_q.tick_irq;
  assign TICK_FLAG_OUT         = s_q.tick_flag;
  assign TICK_COUNT_OUT        = s_q.tick_cnt;
  assign RESET_CAUSE_FLAGS_OUT = s_q.cause;
  assign SYSTEM_RESET_OUT      = s_q.sys_reset;

endmodule
`default_nettype wire

//--- dv/irw_route_assertions.sv
// Checker bound to the interrupt routing block.
`default_nettype none
module irw_route_chk
  import irw_pkg::*;
(
  input wire logic                REF_CLK_IN,
  input wire logic                SRST_IN,
  input wire logic                WATCHDOG_NMI_IN,
  input wire logic                SOFTWARE_RESET_REQUEST_IN,
  input wire logic [NUM_IRQ-1:0]  PERIPH_IRQ_IN,
  input wire logic [NUM_EXT-1:0]  PORT_INPUT_ENABLE_REG_IN,
  input wire logic [NUM_WAKE-1:0] WAKE_SOURCE_ENABLE_IN,
  input wire logic [NUM_IRQ-1:0]  SET_PENDING_IN,
  input wire logic                TICK_FLAG_READ_IN,
  input wire logic [NUM_IRQ-1:0]  CORE_IRQ_OUT,
  input wire logic [NUM_IRQ-1:0]  PENDING_OUT,
  input wire logic                NMI_OUT,
  input wire logic                TICK_IRQ_OUT,
  input wire logic                TICK_FLAG_OUT,
  input wire logic [TICK_W-1:0]   TICK_COUNT_OUT,
  input wire logic [2:0]          RESET_CAUSE_FLAGS_OUT,
  input wire logic                SYSTEM_RESET_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);
  chk_nmi_raise: assert property ($rose(WATCHDOG_NMI_IN) |=> NMI_OUT)
    else $error("nmi not raised");
  chk_soft_reset: assert property (SOFTWARE_RESET_REQUEST_IN |=> SYSTEM_RESET_OUT)
    else $error("no system reset");
  chk_cause_onehot: assert property ($onehot(RESET_CAUSE_FLAGS_OUT))
    else $error("reset cause not one-hot");
  chk_direct_route: assert property (CORE_IRQ_OUT[29:9] == $past(PERIPH_IRQ_IN[29:9]))
    else $error("direct request not passed");
  chk_set_pend: assert property ((PENDING_OUT & $past(SET_PENDING_IN)) == $past(SET_PENDING_IN))
    else $error("forced pending lost");
  chk_pin_off_high: assert property ((!PORT_INPUT_ENABLE_REG_IN[0] && !WAKE_SOURCE_ENABLE_IN[0])
    [*4] |-> CORE_IRQ_OUT[EXT_BASE])
    else $error("disabled pin not high");
  chk_tick_flag: assert property (TICK_IRQ_OUT |-> TICK_FLAG_OUT)
    else $error("tick flag missing");
  chk_flag_hold: assert property (TICK_FLAG_OUT && !TICK_FLAG_READ_IN |=> TICK_FLAG_OUT)
    else $error("tick flag dropped");
  chk_tick_zero: assert property (TICK_IRQ_OUT |-> TICK_COUNT_OUT == 0 || $past(TICK_COUNT_OUT) == 0)
    else $error("tick irq without zero");
  cov_tick: cover property (TICK_IRQ_OUT);
  cov_reset: cover property (SYSTEM_RESET_OUT);
  cov_nmi: cover property (NMI_OUT);
endmodule
bind irw_route irw_route_chk i_chk (.*);
`default_nettype wire

//--- dv/irw_src_model.sv
// Model of the peripherals and pins feeding the routing block.
`default_nettype none
module irw_src_model
  import irw_pkg::*;
(
  input  wire logic               clk,
  input  wire logic [NUM_IRQ-1:0] req_in,
  input  wire logic [NUM_EXT-1:0] pin_in,
  output logic [NUM_IRQ-1:0]      irq_out,
  output logic [NUM_EXT-1:0]      pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial irq_out = '0;
  initial pin_out = '0;
  always @(posedge clk) irq_out <= req_in;
  // Pins rest low so that enabling an input raises no request.
  always @(posedge clk) pin_out <= pin_in;
endmodule
`default_nettype wire

//--- dv/irw_tb.sv
// Self-checking testbench for the interrupt routing block.
`default_nettype none
module testbench
  import irw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic REF_CLK_IN = 0, SRST_IN = 1, RESET_PIN_IN = 1, WATCHDOG_RESET_IN = 0;
  logic WATCHDOG_NMI_IN = 0, SOFTWARE_RESET_REQUEST_IN = 0, TICK_ENABLE_IN = 0;
  logic TICK_FLAG_READ_IN = 0, ACTIVE_VALID_OUT, NMI_OUT, TICK_IRQ_OUT, TICK_FLAG_OUT;
  logic SYSTEM_RESET_OUT, seen;
  logic [NUM_IRQ-1:0] PERIPH_IRQ_IN, SET_PENDING_IN = '0, CLEAR_PENDING_IN = '0;
  logic [NUM_IRQ-1:0] IRQ_ENABLE_IN = '0, CORE_IRQ_OUT, PENDING_OUT, req = '0;
  logic [NUM_EXT-1:0] EXT_PIN_IN, PORT_INPUT_ENABLE_REG_IN = '0;
  logic [NUM_WAKE-1:0] WAKE_SOURCE_ENABLE_IN = '0, WAKE_CLEAR_IN = '0;
  logic [3*NUM_WAKE-1:0] WAKE_ACTIVE_LEVEL_IN = '0;
  logic [2*NUM_IRQ-1:0] PRIORITY_IN = '1;
  logic [TICK_W-1:0] TICK_RELOAD_IN = '0, TICK_COUNT_OUT;
  logic [1:0] OSCILLATOR_SELECT_IN = '0;
  logic [3:0] OSC_TICK_IN = '0;
  logic [4:0] ACTIVE_ID_OUT;
  logic [2:0] RESET_CAUSE_FLAGS_OUT;
  int errors = 0, n_tests = 0;
  irw_route i_dut (.*);
  irw_src_model i_src (.clk(REF_CLK_IN), .req_in(req), .pin_in(4'h0),
    .irq_out(PERIPH_IRQ_IN), .pin_out(EXT_PIN_IN));
  initial forever #50 REF_CLK_IN = ~REF_CLK_IN;
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK_IN);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic t_resets();
    for (int k = 2; k >= 0; k--)
    begin
      cyc(1);
      RESET_PIN_IN <= (k != 0);
      WATCHDOG_RESET_IN <= (k == 1);
      SOFTWARE_RESET_REQUEST_IN <= (k == 2);
      cyc(1);
      {RESET_PIN_IN, WATCHDOG_RESET_IN, SOFTWARE_RESET_REQUEST_IN} <= 3'b100;
      seen = 0;
      repeat (6)
      begin
        #1 seen |= SYSTEM_RESET_OUT;
        cyc(1);
      end
      chk(seen, 1);
      chk(RESET_CAUSE_FLAGS_OUT, 3'h1 << k);
    end
    cyc(1);
    WATCHDOG_NMI_IN <= 1;
    cyc(2);
    #1 chk(NMI_OUT, 1);
  endtask
  task automatic t_tick();
    cyc(1);
    {OSCILLATOR_SELECT_IN, OSC_TICK_IN, TICK_ENABLE_IN} <= {2'h1, 4'hd, 1'b1};
    TICK_RELOAD_IN <= 24'h2;
    cyc(6);
    #1 chk(TICK_COUNT_OUT, 24'h2);
    cyc(1);
    OSC_TICK_IN <= 4'h2;
    cyc(1);
    OSC_TICK_IN <= 4'h0;
    cyc(2);
    #1 chk(TICK_COUNT_OUT, 24'h1);
    cyc(1);
    OSC_TICK_IN <= 4'h2;
    for (int i = 0; i < 12 && TICK_IRQ_OUT !== 1'b1; i++)
    begin
      cyc(1);
      #1;
    end
    chk(TICK_IRQ_OUT, 1);
    cyc(1);
    {OSC_TICK_IN, TICK_FLAG_READ_IN} <= 5'h01;
    #1 chk(TICK_FLAG_OUT, 1);
    cyc(1);
    TICK_FLAG_READ_IN <= 0;
    cyc(2);
    #1 chk(TICK_FLAG_OUT, 0);
  endtask
  task automatic t_route();
    cyc(1);
    req <= 32'h0000_0200;
    WAKE_ACTIVE_LEVEL_IN[17:15] <= LVL_FALL;
    WAKE_SOURCE_ENABLE_IN <= 6'h20;
    cyc(4);
    #1 chk(CORE_IRQ_OUT[9], 1);
    chk(CORE_IRQ_OUT[8:5], 4'hf);
    cyc(1);
    req[30] <= 1;
    PORT_INPUT_ENABLE_REG_IN <= 4'hf;
    cyc(6);
    #1 chk(CORE_IRQ_OUT[30:5], 26'h0000010);
    cyc(1);
    req[30] <= 0;
    cyc(8);
    #1 chk(CORE_IRQ_OUT[30], 1);
    cyc(1);
    WAKE_CLEAR_IN <= 6'h20;
    cyc(1);
    WAKE_CLEAR_IN <= 6'h00;
    cyc(2);
    #1 chk(CORE_IRQ_OUT[30], 0);
  endtask
  task automatic t_pend();
    cyc(1);
    {req, WAKE_SOURCE_ENABLE_IN, IRQ_ENABLE_IN} <= {32'h0, 6'h0, 32'hffff_ffff};
    cyc(3);
    CLEAR_PENDING_IN <= '1;
    cyc(1);
    {CLEAR_PENDING_IN, SET_PENDING_IN} <= {32'h0, 32'h0210_0000};
    cyc(1);
    SET_PENDING_IN <= '0;
    cyc(3);
    #1 chk(PENDING_OUT, 32'h0210_0000);
    chk({ACTIVE_VALID_OUT, ACTIVE_ID_OUT}, 6'h34);
    cyc(1);
    PRIORITY_IN[51:50] <= 2'h0;
    cyc(3);
    #1 chk(ACTIVE_ID_OUT, 5'd25);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    cyc(10);
    SRST_IN <= 0;
    cyc(1);
    #1 chk(RESET_CAUSE_FLAGS_OUT, CAUSE_RESET_VAL);
    t_resets();
    t_tick();
    t_route();
    t_pend();
    tally_and_finish();
  end
  initial
  begin
    cyc(600);
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
